// ### src/sarc_defines.svh
`ifndef SARC_DEFINES_SVH
`define SARC_DEFINES_SVH

// ------------------------------------------------
// register byte offsets
// ------------------------------------------------
`define SARC_OFF_CTL_A 8'h00
`define SARC_OFF_REF_CFG 8'h04
`define SARC_OFF_CTL_C 8'h08
`define SARC_OFF_RES_HI 8'h0C
`define SARC_OFF_RES_LO 8'h10
`define SARC_OFF_STATUS 8'h14

// ------------------------------------------------
// field positions
// ------------------------------------------------
`define SARC_ON_BIT 0
`define SARC_GO_BIT 1
`define SARC_DONE_BIT 0
`define SARC_WORD_LSB 2

// ------------------------------------------------
// reset values and codes
// ------------------------------------------------
`define SARC_PCFG_ALL_ANALOG 4'h0
`define SARC_PCFG_PORTB_DIG 4'h7
`define SARC_PCFG_LAST_ALL_A 4'h4
`define SARC_ALL_PINS 11'h7FF
`define SARC_NUM_CH 4'hB
`define SARC_SMALL_GAP_LO 4'h5
`define SARC_SMALL_GAP_HI 4'h7
`define SARC_FULL_SCALE 10'h3FF
`define SARC_MSB_TRIAL 10'h200
`define SARC_RESP_OKAY 2'h0
`define SARC_RESP_SLVERR 2'h2

// ------------------------------------------------
// timing
// ------------------------------------------------
`define SARC_CLK_NS 10
`define SARC_TCY_NS 40
`define SARC_CONV_TADS 5'hA
`define SARC_ACQ_TABLE {5'h14, 5'h10, 5'h0C, 5'h08, 5'h06, 5'h04, 5'h02, 5'h00}
`define SARC_DIV_SHIFT {3'h0, 3'h6, 3'h4, 3'h2, 3'h0, 3'h5, 3'h3, 3'h1}

`endif

// ### src/sarc_pkg.sv
package sarc_pkg;

	typedef enum logic [1:0]
	{
		SARC_IDLE = 2'h0,
		SARC_DELAY = 2'h1,
		SARC_ACQ = 2'h3,
		SARC_CONV = 2'h2
	} sarc_state_t;

	typedef struct packed
	{
		logic [1:0] unused;
		logic [3:0] channel_select;
		logic convert_go_flag;
		logic converter_on;
	} sarc_ctl_a_t;

	typedef struct packed
	{
		logic [1:0] unused;
		logic neg_ref_select;
		logic pos_ref_select;
		logic [3:0] pin_analog_config;
	} sarc_ref_cfg_t;

	typedef struct packed
	{
		logic result_justify;
		logic unused;
		logic [2:0] acq_time_select;
		logic [2:0] conv_clock_select;
	} sarc_ctl_c_t;

endpackage

// ### src/sarc_top.sv
// How it works
// - eleven analog channels on large variant, eight on small, 10-bit result
// - channel_select in bits 5..2 picks channel 0..10; codes 11..15 unused
// - converting an unimplemented channel returns full scale
// - convert_go_flag reads 1 while busy, 0 when idle
// - converter_on bit 0 enables the converter
// - neg_ref_select bit 5 picks external low reference, else analog ground
// - pos_ref_select bit 4 picks external high reference, else analog supply
// - pin_analog_config 0..4 all analog; each higher code turns one more pin digital
// - strap at reset loads pin_analog_config 0000 or 0111
// - result_justify bit 7 picks right or left justification
// - acq_time_select sets acquisition of 0,2,4,6,8,12,16,20 bit periods
// - conv_clock_select picks system divide or the rc clock
// - rc clock source adds one instruction cycle before the clock runs
// - only the rc clock keeps converting during sleep
// - result found by successive approximation of the held sample
// - reset clears registers except the strapped pin_analog_config, turns off and aborts conversion
// - completion loads results, clears go, sets done flag
// - zero acquisition converts at once, else samples first
// - a conversion takes eleven bit periods
// - after completion the selected channel is sampled again
//
// Implementation choices: the register offsets and register access over AXI4-Lite.
`include "sarc_defines.svh"

module sarc_top
	import sarc_pkg::*;
#(
	parameter int ADDR_W = 8,
	parameter int RC_TAD_NS = 1200
)
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// axi4-lite write
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// axi4-lite read
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// device straps and state
	input wire logic portb_analog_default,
	input wire logic large_variant,
	input wire logic device_sleep,
	// analog front end
	input wire logic comparator_above,
	output logic [3:0] channel_select,
	output logic sample_enable,
	output logic [9:0] dac_code,
	output logic neg_ref_select,
	output logic pos_ref_select,
	output logic [10:0] pin_analog
);

	localparam int TCY_CYCLES = (`SARC_TCY_NS + `SARC_CLK_NS - 1) / `SARC_CLK_NS;
	localparam int RC_CYCLES = (RC_TAD_NS / `SARC_CLK_NS < 1) ? 1 : RC_TAD_NS / `SARC_CLK_NS;

	// refused at elaboration
	if (ADDR_W < 5 || ADDR_W > 8)
		$error("ADDR_W must lie in 5..8");
	if (RC_CYCLES > 256)
		$error("RC_TAD_NS too long for the divider");

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	function automatic logic [10:0] analog_mask(input logic [3:0] code);
		logic [3:0] dig;
		dig = 4'h0;
		if (code > `SARC_PCFG_LAST_ALL_A)
			dig = code - `SARC_PCFG_LAST_ALL_A;
		return `SARC_ALL_PINS >> dig;
	endfunction

	function automatic logic [4:0] acq_tads(input logic [2:0] code);
		logic [39:0] tbl;
		tbl = `SARC_ACQ_TABLE;
		return tbl[code*5 +: 5];
	endfunction

	function automatic logic [8:0] div_count(input logic [2:0] code);
		logic [23:0] tbl;
		tbl = `SARC_DIV_SHIFT;
		if (code[1:0] == 2'h3)
			return 9'(RC_CYCLES);
		return 9'(9'h001 << tbl[code*3 +: 3]);
	endfunction

	function automatic logic channel_missing(input logic [3:0] ch, input logic big);
		logic gap;
		gap = (ch >= `SARC_SMALL_GAP_LO) && (ch <= `SARC_SMALL_GAP_HI);
		return (ch >= `SARC_NUM_CH) || (!big && gap);
	endfunction

	// ------------------------------------------------
	// state
	// ------------------------------------------------
	sarc_ctl_a_t ctl_a_q, ctl_a_d;
	sarc_ref_cfg_t ref_q, ref_d;
	sarc_ctl_c_t ctl_c_q, ctl_c_d;
	logic [7:0] res_hi_q, res_hi_d;
	logic [7:0] res_lo_q, res_lo_d;
	logic done_q, done_d;
	sarc_state_t state_q, state_d;
	logic [8:0] div_q, div_d;
	logic [4:0] tad_q, tad_d;
	logic [9:0] dac_q, dac_d;
	logic [9:0] trial_q, trial_d;
	logic ch_bad_q, ch_bad_d;

	logic aw_have_q, aw_have_d;
	logic w_have_q, w_have_d;
	logic [ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [7:0] wbyte_q, wbyte_d;
	logic wlane_q, wlane_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [31:0] rdata_q, rdata_d;

	logic do_write;
	logic tick;
	logic rc_src;
	logic [7:0] wr_off;
	logic [7:0] rd_off;
	logic [9:0] kept;

	assign rc_src = ctl_c_q.conv_clock_select[1:0] == 2'h3;
	assign do_write = aw_have_q && w_have_q && !bvalid_q;
	assign wr_off = 8'(awaddr_q);
	assign rd_off = 8'(s_axi_araddr);
	// sleep freezes the divided system clock, never the rc clock
	assign tick = (div_q == 9'h001) && (rc_src || !device_sleep);
	assign kept = comparator_above ? dac_q : (dac_q ^ trial_q);

	// ------------------------------------------------
	// bus channels
	// ------------------------------------------------
	assign s_axi_awready = !aw_have_q && !bvalid_q;
	assign s_axi_wready = !w_have_q && !bvalid_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	always_comb
	begin
		aw_have_d = aw_have_q;
		w_have_d = w_have_q;
		awaddr_d = awaddr_q;
		wbyte_d = wbyte_q;
		wlane_d = wlane_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_d = 1'b1;
			wbyte_d = s_axi_wdata[7:0];
			wlane_d = s_axi_wstrb[0];
		end
		if (do_write)
		begin
			aw_have_d = 1'b0;
			w_have_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = (wr_off > `SARC_OFF_STATUS || wr_off[1:0] != 2'h0) ? `SARC_RESP_SLVERR : `SARC_RESP_OKAY;
		end
		if (bvalid_q && s_axi_bready)
			bvalid_d = 1'b0;
		if (rvalid_q && s_axi_rready)
			rvalid_d = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			rvalid_d = 1'b1;
			rresp_d = `SARC_RESP_OKAY;
			rdata_d = 32'h0;
			unique case (rd_off)
				`SARC_OFF_CTL_A:
				begin
					rdata_d[7:0] = ctl_a_q;
					rdata_d[`SARC_GO_BIT] = ctl_a_q.converter_on && state_q != SARC_IDLE;
				end
				`SARC_OFF_REF_CFG: rdata_d[7:0] = ref_q;
				`SARC_OFF_CTL_C: rdata_d[7:0] = ctl_c_q;
				`SARC_OFF_RES_HI: rdata_d[7:0] = res_hi_q;
				`SARC_OFF_RES_LO: rdata_d[7:0] = res_lo_q;
				`SARC_OFF_STATUS: rdata_d[`SARC_DONE_BIT] = done_q;
				default: rresp_d = `SARC_RESP_SLVERR;
			endcase
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			awaddr_q <= '0;
			wbyte_q <= 8'h00;
			wlane_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `SARC_RESP_OKAY;
			rvalid_q <= 1'b0;
			rresp_q <= `SARC_RESP_OKAY;
			rdata_q <= 32'h0;
		end
		else
		begin
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			awaddr_q <= awaddr_d;
			wbyte_q <= wbyte_d;
			wlane_q <= wlane_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end

	// ------------------------------------------------
	// registers and sequencer
	// ------------------------------------------------
	always_comb
	begin
		logic wr;
		logic start;
		logic [9:0] r;
		wr = do_write && wlane_q;
		start = 1'b0;
		r = ch_bad_q ? `SARC_FULL_SCALE : kept;
		ctl_a_d = ctl_a_q;
		ref_d = ref_q;
		ctl_c_d = ctl_c_q;
		res_hi_d = res_hi_q;
		res_lo_d = res_lo_q;
		done_d = done_q;
		state_d = state_q;
		div_d = div_q;
		tad_d = tad_q;
		dac_d = dac_q;
		trial_d = trial_q;
		ch_bad_d = ch_bad_q;
		if (wr && wr_off == `SARC_OFF_CTL_A)
		begin
			ctl_a_d.channel_select = wbyte_q[5:2];
			ctl_a_d.converter_on = wbyte_q[`SARC_ON_BIT];
			start = wbyte_q[`SARC_GO_BIT] && wbyte_q[`SARC_ON_BIT] && ctl_a_q.converter_on
				&& state_q == SARC_IDLE;
		end
		if (wr && wr_off == `SARC_OFF_REF_CFG)
			ref_d = sarc_ref_cfg_t'({2'h0, wbyte_q[5:0]});
		if (wr && wr_off == `SARC_OFF_CTL_C)
			ctl_c_d = sarc_ctl_c_t'({wbyte_q[7], 1'b0, wbyte_q[5:0]});
		if (wr && wr_off == `SARC_OFF_STATUS && wbyte_q[`SARC_DONE_BIT])
			done_d = 1'b0;
		// the bit period divider only runs while a conversion is under way
		// a divider stalled by sleep waits at one instead of wrapping
		if (state_q == SARC_IDLE || state_q == SARC_DELAY || tick)
			div_d = div_count(ctl_c_q.conv_clock_select);
		else if (div_q != 9'h001)
			div_d = div_q - 9'h001;
		unique case (state_q)
			SARC_IDLE:
				if (start)
				begin
					ch_bad_d = channel_missing(ctl_a_q.channel_select, large_variant);
					tad_d = 5'h0;
					if (rc_src)
					begin
						state_d = SARC_DELAY;
						tad_d = 5'(TCY_CYCLES - 1);
					end
					else if (acq_tads(ctl_c_q.acq_time_select) != 5'h0)
						state_d = SARC_ACQ;
					else
					begin
						state_d = SARC_CONV;
						dac_d = `SARC_MSB_TRIAL;
						trial_d = `SARC_MSB_TRIAL;
					end
				end
			SARC_DELAY:
				if (tad_q == 5'h0)
				begin
					if (acq_tads(ctl_c_q.acq_time_select) != 5'h0)
						state_d = SARC_ACQ;
					else
					begin
						state_d = SARC_CONV;
						dac_d = `SARC_MSB_TRIAL;
						trial_d = `SARC_MSB_TRIAL;
					end
				end
				else
					tad_d = tad_q - 5'h1;
			SARC_ACQ:
				if (tick)
				begin
					if (tad_q + 5'h1 >= acq_tads(ctl_c_q.acq_time_select))
					begin
						state_d = SARC_CONV;
						tad_d = 5'h0;
						dac_d = `SARC_MSB_TRIAL;
						trial_d = `SARC_MSB_TRIAL;
					end
					else
						tad_d = tad_q + 5'h1;
				end
			SARC_CONV:
				if (tick)
				begin
					tad_d = tad_q + 5'h1;
					// first period settles the hold, then one bit per period
					if (tad_q != 5'h0)
					begin
						trial_d = trial_q >> 1;
						dac_d = kept | (trial_q >> 1);
					end
					if (tad_q == `SARC_CONV_TADS)
					begin
						state_d = SARC_IDLE;
						tad_d = 5'h0;
						dac_d = 10'h000;
						trial_d = 10'h000;
						done_d = 1'b1;
						if (ctl_c_q.result_justify)
						begin
							res_hi_d = {6'h00, r[9:8]};
							res_lo_d = r[7:0];
						end
						else
						begin
							res_hi_d = r[9:2];
							res_lo_d = {r[1:0], 6'h00};
						end
					end
				end
		endcase
		// turning the converter off abandons any conversion
		if (!ctl_a_d.converter_on)
		begin
			state_d = SARC_IDLE;
			dac_d = 10'h000;
			trial_d = 10'h000;
		end
		ctl_a_d.convert_go_flag = state_d != SARC_IDLE;
		ctl_a_d.unused = 2'h0;
	end

	always_ff @(posedge sys_clk)
	begin
		if (sys_rst)
		begin
			// strap sampled while the synchronous reset is held
			ctl_a_q <= '0;
			ref_q <= '0;
			ref_q.pin_analog_config <= portb_analog_default ? `SARC_PCFG_ALL_ANALOG : `SARC_PCFG_PORTB_DIG;
			ctl_c_q <= '0;
			res_hi_q <= 8'h00;
			res_lo_q <= 8'h00;
			done_q <= 1'b0;
			state_q <= SARC_IDLE;
			div_q <= 9'h001;
			tad_q <= 5'h0;
			dac_q <= 10'h000;
			trial_q <= 10'h000;
			ch_bad_q <= 1'b0;
		end
		else
		begin
			ctl_a_q <= ctl_a_d;
			ref_q <= ref_d;
			ctl_c_q <= ctl_c_d;
			res_hi_q <= res_hi_d;
			res_lo_q <= res_lo_d;
			done_q <= done_d;
			state_q <= state_d;
			div_q <= div_d;
			tad_q <= tad_d;
			dac_q <= dac_d;
			trial_q <= trial_d;
			ch_bad_q <= ch_bad_d;
		end
	end

	// ------------------------------------------------
	// front end controls
	// ------------------------------------------------
	always_comb
	begin
		channel_select = ctl_a_q.channel_select;
		sample_enable = ctl_a_q.converter_on && state_q != SARC_CONV;
		dac_code = dac_q;
		neg_ref_select = ref_q.neg_ref_select;
		pos_ref_select = ref_q.pos_ref_select;
		pin_analog = analog_mask(ref_q.pin_analog_config);
	end

endmodule

// ### sim/sarc_top_properties.sv
module sarc_top_properties
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	// front end
	input wire logic sample_enable,
	input wire logic [9:0] dac_code,
	input wire logic neg_ref_select,
	input wire logic pos_ref_select,
	input wire logic [10:0] pin_analog
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (sys_rst);

	property p_reset_state;
		$fell(sys_rst) |-> dac_code == 10'h000 && !sample_enable && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_reset_state: assert property (p_reset_state) else $error("state not cleared by reset");
	property p_ref_by_write;
		$changed({neg_ref_select, pos_ref_select}) && !$past(sys_rst) |-> $rose(s_axi_bvalid);
	endproperty
	a_ref_by_write: assert property (p_ref_by_write) else $error("reference select moved without write");
	property p_pins_contig;
		((pin_analog + 11'h001) & pin_analog) == 11'h000;
	endproperty
	a_pins_contig: assert property (p_pins_contig) else $error("analog pins not contiguous from pin 0");
	property p_trial_msb;
		$rose(|dac_code) |-> dac_code == 10'h200;
	endproperty
	a_trial_msb: assert property (p_trial_msb) else $error("first trial is not the top bit");
	property p_no_sample_conv;
		dac_code != 10'h000 |-> !sample_enable;
	endproperty
	a_no_sample_conv: assert property (p_no_sample_conv) else $error("sampling during conversion");
	property p_resume;
		$fell(|dac_code) && !$past(sys_rst) && !$rose(s_axi_bvalid) |-> sample_enable;
	endproperty
	a_resume: assert property (p_resume) else $error("sampling not resumed after conversion");
	property p_write_answer;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
	endproperty
	a_write_answer: assert property (p_write_answer) else $error("write response late");
	property p_read_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data dropped before taken");
	property p_read_upper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000;
	endproperty
	a_read_upper: assert property (p_read_upper) else $error("upper read bits not zero");
endmodule

bind sarc_top sarc_top_properties u_props (.sys_clk, .sys_rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
	.s_axi_wready, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .sample_enable, .dac_code,
	.neg_ref_select, .pos_ref_select, .pin_analog);

// ### sim/sarc_front_model.sv
module sarc_front_model
(
	// clock
	input wire logic sys_clk,
	// converter side
	input wire logic sample_enable,
	input wire logic [9:0] dac_code,
	// analog source
	input wire logic [9:0] source_level,
	output logic comparator_above
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] held_q = 10'h000;

	// hold capacitor follows the pin only while sampling
	always @(posedge sys_clk)
	begin
		if (sample_enable)
			held_q <= source_level;
	end
	assign comparator_above = (held_q >= dac_code);
endmodule

// ### sim/sar_adc_control_tb.sv
module sar_adc_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic [7:0] s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic portb_analog_default = 1'b0, large_variant = 1'b1, device_sleep = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic comparator_above, neg_ref_select, pos_ref_select, sample_enable;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] channel_select;
	logic [9:0] dac_code;
	logic [9:0] source_level = 10'h000;
	logic [10:0] pin_analog;
	logic [31:0] seed = 32'h00011056;
	logic [31:0] rv;
	int num_errors = 0;
	int samples_checked = 0;
	int conv_cycles = 0;

	always #5 sys_clk = ~sys_clk;

	// conversion length, counted while a trial code stands
	always @(negedge sys_clk)
	begin
		if (dac_code != 10'h000)
			conv_cycles <= conv_cycles + 1;
	end

	// rc period shortened to four system clocks
	sarc_top #(.RC_TAD_NS(40)) uut (.sys_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.portb_analog_default, .large_variant, .device_sleep, .comparator_above, .channel_select, .sample_enable,
		.dac_code, .neg_ref_select, .pos_ref_select, .pin_analog);
	sarc_front_model front (.sys_clk, .sample_enable, .dac_code, .source_level, .comparator_above);

	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic [10:0] exp_pins(input logic [3:0] c);
		return (c <= 4'h4) ? 11'h7FF : (11'h7FF >> (c - 4'h4));
	endfunction

	// system clocks per bit period; rc period shortened to four clocks
	function automatic int exp_div(input logic [2:0] c);
		case (c)
			3'h0: return 2;
			3'h1: return 8;
			3'h2: return 32;
			3'h4: return 4;
			3'h5: return 16;
			3'h6: return 64;
			default: return 4;
		endcase
	endfunction

	task final_report();
		if (num_errors == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ready is sampled mid-cycle; it only depends on registered state
	// bready/rready held back two cycles at random so the answer must stand
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
		output logic [1:0] r);
		int n;
		logic ta, tw, tr, fin;
		logic slow;
		logic [31:0] rs;
		n = 0;
		fin = 1'b0;
		rs = rnd();
		slow = rs[0];
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_araddr <= a;
		s_axi_awvalid <= w;
		s_axi_wvalid <= w;
		s_axi_bready <= w && !slow;
		s_axi_arvalid <= !w;
		s_axi_rready <= !w && !slow;
		while (!fin)
		begin
			@(negedge sys_clk);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			tr = s_axi_arvalid & s_axi_arready;
			fin = (s_axi_bvalid & s_axi_bready) | (s_axi_rvalid & s_axi_rready);
			q = s_axi_rdata;
			r = w ? s_axi_bresp : s_axi_rresp;
			@(posedge sys_clk);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
			if (tr)
				s_axi_arvalid <= 1'b0;
			if (fin)
			begin
				s_axi_bready <= 1'b0;
				s_axi_rready <= 1'b0;
			end
			else if (n == 1)
			begin
				s_axi_bready <= w;
				s_axi_rready <= !w;
			end
			n++;
			if (n > 64)
			begin
				num_errors++;
				final_report();
			end
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b1, a, d, q, r);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic [31:0] q;
		logic [1:0] r;
		bus(1'b0, a, 32'h0, q, r);
		chk(q, e);
		chk({30'h0, r}, {30'h0, er});
	endtask

	task automatic conv(input logic [3:0] ch, input logic [2:0] acq, input logic [2:0] ck, input logic [9:0] v,
		input logic j, input logic lg, input logic slp);
		logic [31:0] q;
		logic [1:0] r;
		logic [9:0] e;
		int n;
		int c0;
		e = (!lg && ch >= 4'h5 && ch <= 4'h7) ? 10'h3FF : v;
		source_level <= v;
		large_variant <= lg;
		device_sleep <= slp;
		wr(8'h08, {24'h0, j, 1'b0, acq, ck}, 2'h0);
		wr(8'h00, {26'h0, ch, 2'b01}, 2'h0);
		chk({28'h0, channel_select}, {28'h0, ch});
		c0 = conv_cycles;
		wr(8'h00, {26'h0, ch, 2'b11}, 2'h0);
		rd(8'h00, {26'h0, ch, 2'b11}, 2'h0);
		n = 0;
		q = 32'h2;
		while (q[1] && n < 2000)
		begin
			bus(1'b0, 8'h00, 32'h0, q, r);
			n++;
		end
		chk(q, {26'h0, ch, 2'b01});
		chk(conv_cycles - c0, 11 * exp_div(ck));
		rd(8'h0C, j ? {30'h0, e[9:8]} : {24'h0, e[9:2]}, 2'h0);
		rd(8'h10, j ? {24'h0, e[7:0]} : {24'h0, e[1:0], 6'h00}, 2'h0);
		rd(8'h14, 32'h1, 2'h0);
		wr(8'h14, 32'h1, 2'h0);
		rd(8'h14, 32'h0, 2'h0);
		device_sleep <= 1'b0;
		repeat (128) @(posedge sys_clk);
	endtask

	initial
	begin
		repeat (16) @(posedge sys_clk);
		sys_rst <= 1'b0;
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h7, 2'h0);
		rd(8'h08, 32'h0, 2'h0);
		rd(8'h18, 32'h0, 2'h2);
		wr(8'h18, 32'hFF, 2'h2);
		wr(8'h0C, 32'hFF, 2'h0);
		rd(8'h0C, 32'h0, 2'h0);
		for (int i = 0; i < 16; i++)
		begin
			rv = (rnd() & 32'h30) | i;
			wr(8'h04, rv, 2'h0);
			rd(8'h04, rv, 2'h0);
			chk({21'h0, pin_analog}, {21'h0, exp_pins(i[3:0])});
			chk({30'h0, neg_ref_select, pos_ref_select}, {30'h0, rv[5:4]});
		end
		wr(8'h04, 32'h0, 2'h0);
		// a write without byte lane 0 leaves the register alone
		s_axi_wstrb <= 4'h0;
		wr(8'h04, 32'h3F, 2'h0);
		s_axi_wstrb <= 4'hF;
		rd(8'h04, 32'h0, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		rd(8'h00, 32'h1, 2'h0);
		wr(8'h00, 32'h0, 2'h0);
		wr(8'h00, 32'h2, 2'h0);
		rd(8'h00, 32'h0, 2'h0);
		conv(4'h5, 3'h0, 3'h0, 10'h155, 1'b0, 1'b0, 1'b0);
		conv(4'hA, 3'h7, 3'h6, 10'h3FE, 1'b1, 1'b1, 1'b0);
		conv(4'h3, 3'h1, 3'h3, 10'h001, 1'b0, 1'b1, 1'b1);
		for (int k = 0; k < 8; k++)
		begin
			rv = rnd();
			conv(rv[3:0] % 4'hB, k[2:0], k[2:0], rv[13:4], rv[14], rv[15], rv[16] & (k[1:0] == 2'b11));
		end
		// a divided system clock halts in sleep and resumes on wake
		device_sleep <= 1'b1;
		wr(8'h08, 32'h0, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (64) @(posedge sys_clk);
		rd(8'h00, 32'h3, 2'h0);
		device_sleep <= 1'b0;
		repeat (64) @(posedge sys_clk);
		rd(8'h00, 32'h1, 2'h0);
		// abort a conversion in flight with the strap now set
		wr(8'h08, 32'h0, 2'h0);
		wr(8'h00, 32'h1, 2'h0);
		wr(8'h00, 32'h3, 2'h0);
		repeat (8) @(posedge sys_clk);
		portb_analog_default <= 1'b1;
		sys_rst <= 1'b1;
		@(posedge sys_clk);
		sys_rst <= 1'b0;
		@(negedge sys_clk);
		chk({22'h0, dac_code}, 32'h0);
		rd(8'h00, 32'h0, 2'h0);
		rd(8'h04, 32'h0, 2'h0);
		final_report();
	end
endmodule
